//--- core/key_limit_pkg.sv
// key-use limiter: offsets, fields, reset values and encodings
// assumes a 32-bit AHB-Lite slave decoding the low address byte
package key_limit_pkg;
    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ONE_SHOT = 8'h08;
    localparam logic [7:0] OFS_REFRESH_OK = 8'h0C;
    localparam logic [7:0] OFS_RKEY_ZERO = 8'h10;
    localparam logic [7:0] OFS_REMAIN_LO = 8'h14;
    localparam logic [7:0] OFS_REMAIN_HI = 8'h18;
    localparam logic [7:0] OFS_SCRATCH = 8'h1C;
    localparam logic [7:0] OFS_FINAL0 = 8'h44;
    localparam logic [7:0] OFS_FINAL3 = 8'h50;
    // ************************************************
    // command word fields
    // ************************************************
    localparam int CMD_MATCH_BIT = 2;
    localparam int CMD_SECOND_BIT = 3;
    localparam int CMD_PARENT_LSB = 4;
    localparam int CMD_MODE_LSB = 8;
    localparam int CMD_SEL_LSB = 16;
    typedef enum logic [1:0] {
        OP_CRYPTO_USE = 2'h0,
        OP_ACCESS = 2'h1,
        OP_REFRESH = 2'h2,
        OP_COMPARE = 2'h3
    } op_t;
    // ************************************************
    // scratch flags, status bits, constants
    // ************************************************
    localparam int SCR_ORIGIN = 0;
    localparam int SCR_GEN = 1;
    localparam int SCR_CMP = 2;
    localparam int SCR_VALID = 3;
    localparam int STS_DONE = 0;
    localparam int STS_ERR = 1;
    localparam int STS_GRANT = 2;
    localparam int STS_COPY = 3;
    localparam int STS_SLOT_LSB = 4;
    localparam logic [7:0] BITMAP_FULL = 8'hFF;
    localparam logic [7:0] BITMAP_EMPTY = 8'h00;
    localparam logic [127:0] FINAL_RESET = {16{8'hFF}};
    localparam logic [3:0] LIMITED_SLOT_MAX = 4'h7;
    localparam logic [3:0] FINAL_SLOT = 4'hF;
    localparam logic [7:0] MODE_COPY_A = 8'h01;
    localparam logic [7:0] MODE_COPY_B = 8'h05;
    localparam int MODE_ORIGIN_BIT = 2;
endpackage

//--- core/use_bit_if.sv
// carrier between the limiter and its use-bit consumer
// assumes both ends sit in the same clock domain
`timescale 1ns/1ns
interface use_bit_if;
    logic [127:0] map_in;
    logic [127:0] map_out;
    logic empty;
    modport consumer (input map_in, output map_out, output empty);
    modport requester (output map_in, input map_out, input empty);
endinterface

//--- core/use_bit_consumer.sv
// clears the highest set bit of a use bitmap, flags an empty map
// assumes bit 127 is scanned first
`timescale 1ns/1ns
module use_bit_consumer (
    use_bit_if.consumer ub
);
    // ************************************************
    // downward scan for the first set bit
    // ************************************************
    always_comb begin
        logic found;
        found = 1'b0;
        ub.map_out = ub.map_in;
        for (int i = 127; i >= 0; i--) begin
            if (!found && ub.map_in[i]) begin
                ub.map_out[i] = 1'b0;
                found = 1'b1;
            end
        end
        ub.empty = ~|ub.map_in;
    end
endmodule

//--- core/key_use_limiter.sv
// key-use limiter and password copy gate behind an AHB-Lite slave
// assumes single word transfers and a hash engine reporting match
`timescale 1ns/1ns
// Function
// - use limits on slots 0..7 only when enabled; ignored for 8..14
// - limited slot with empty bitmap gives an error before use
// - each limited use clears the highest set bitmap bit
// - access commands ignore limits and keep the bitmaps
// - key refresh errors when a limited parent bitmap is empty
// - refresh ignores target limits and fills the bitmap of a target 0..7 with ones; key 15 is not refilled
// - refresh allowed only when target write policy bit 13 is set
// - key 15 with limit enabled uses the final bitmap
// - key 15 errors when the whole final bitmap is zero
// - key 15 use clears first set bit from byte 68 bit 7 on
// - final bitmap bits never come back; at most 128 uses
// - access and copy leave the final bitmap unchanged
// - copy needs mode 0x01 or 0x05 and origin flag equal mode bit 2
// - copy needs the target read key pointer zero
// - target is password slot, or slot plus one for a secondary
// - message is password slot then scratch nonce
// - on match copy target to scratch and set its flags
// - slot is selector low four bits; hash keeps all 16 bits
module key_use_limiter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic key_use_grant,
    output logic [3:0] key_slot,
    output logic [15:0] hash_selector,
    output logic copy_strobe,
    output logic [3:0] copy_slot
);
    typedef enum logic {ST_IDLE, ST_EXEC} fsm_t;
    typedef struct packed {
        fsm_t fsm;
        logic active;
        logic wr;
        logic [7:0] addr;
        logic [31:0] cmd;
        logic [15:0] one_shot;
        logic [15:0] refresh_ok;
        logic [15:0] rkey_zero;
        logic [63:0] remain;
        logic [3:0] scratch;
        logic [127:0] final_map;
        logic [7:0] status;
        logic [31:0] rdata;
        logic ready;
        logic grant;
        logic [3:0] slot;
        logic [15:0] selector;
        logic copy;
        logic [3:0] copy_slot;
    } state_t;

    state_t q;
    state_t d;
    use_bit_if ub ();

    // ************************************************
    // helpers
    // ************************************************
    // limit applies to enabled slots 0..7 and to slot 15 only
    function automatic logic is_limited(input logic [3:0] s, input logic [15:0] en);
        is_limited = en[s] && (s <= key_limit_pkg::LIMITED_SLOT_MAX ||
                     s == key_limit_pkg::FINAL_SLOT);
    endfunction

    // final-map word k: byte 68+4k in bits 7:0, vector msb is byte 68
    function automatic logic [31:0] final_word(input logic [127:0] m, input logic [1:0] k);
        final_word = '0;
        for (int j = 0; j < 4; j++) begin
            final_word[j*8 +: 8] = m[127 - 8*(4*int'(k) + j) -: 8];
        end
    endfunction

    function automatic logic [127:0] final_and(input logic [127:0] m, input logic [1:0] k,
                                               input logic [31:0] w);
        final_and = m;
        for (int j = 0; j < 4; j++) begin
            final_and[127 - 8*(4*int'(k) + j) -: 8] = m[127 - 8*(4*int'(k) + j) -: 8] &
                                                       w[j*8 +: 8];
        end
    endfunction

    // ************************************************
    // command decode
    // ************************************************
    // enum and its literals live in the package; local aliases keep the decode readable
    typedef key_limit_pkg::op_t op_t;
    localparam op_t OP_CRYPTO_USE = key_limit_pkg::OP_CRYPTO_USE;
    localparam op_t OP_ACCESS = key_limit_pkg::OP_ACCESS;
    localparam op_t OP_REFRESH = key_limit_pkg::OP_REFRESH;
    localparam op_t OP_COMPARE = key_limit_pkg::OP_COMPARE;
    op_t op;
    logic [15:0] sel;
    logic [3:0] use_slot;
    logic [3:0] tgt;
    logic [7:0] mode;
    logic copy_ok;
    logic exec;

    assign exec = q.fsm == ST_EXEC;
    assign op = op_t'(q.cmd[1:0]);
    assign sel = q.cmd[key_limit_pkg::CMD_SEL_LSB +: 16];
    assign mode = q.cmd[key_limit_pkg::CMD_MODE_LSB +: 8];
    // refresh consumes a use of its parent, others of the selected key
    assign use_slot = (op == OP_REFRESH) ? q.cmd[key_limit_pkg::CMD_PARENT_LSB +: 4] :
                      sel[3:0];
    // copy target is the password slot or the one above it
    assign tgt = sel[3:0] + {3'h0, q.cmd[key_limit_pkg::CMD_SECOND_BIT]};
    assign copy_ok = (mode == key_limit_pkg::MODE_COPY_A || mode == key_limit_pkg::MODE_COPY_B)
                     && q.scratch[key_limit_pkg::SCR_ORIGIN] == mode[key_limit_pkg::MODE_ORIGIN_BIT]
                     && q.rkey_zero[tgt];

    // feed the consumer with the map of the key about to be used
    assign ub.map_in = (use_slot == key_limit_pkg::FINAL_SLOT) ? q.final_map :
                       {q.remain[use_slot[2:0]*8 +: 8], 120'h0};

    use_bit_consumer u_consume (
        .ub(ub)
    );

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic err;
        err = 1'b0;
        d = q;
        d.ready = 1'b1;
        d.grant = 1'b0;
        d.copy = 1'b0;
        d.fsm = ST_IDLE;
        // command execution, one cycle after the command write
        if (exec) begin
            d.slot = sel[3:0];
            d.selector = sel;
            unique case (op)
                OP_CRYPTO_USE, OP_REFRESH: begin
                    if (op == OP_REFRESH && !q.refresh_ok[sel[3:0]]) begin
                        err = 1'b1;
                    end else if (is_limited(use_slot, q.one_shot)) begin
                        if (ub.empty) begin
                            err = 1'b1;
                        end else if (use_slot == key_limit_pkg::FINAL_SLOT) begin
                            d.final_map = ub.map_out;
                        end else begin
                            d.remain[use_slot*8 +: 8] = ub.map_out[127:120];
                        end
                    end
                    if (!err && op == OP_REFRESH && sel[3:0] <= key_limit_pkg::LIMITED_SLOT_MAX) begin
                        d.remain[sel[2:0]*8 +: 8] = key_limit_pkg::BITMAP_FULL;
                    end
                    d.grant = !err;
                end
                OP_ACCESS: begin
                    d.grant = 1'b1;
                end
                OP_COMPARE: begin
                    // message: password slot key_slot, then scratch nonce
                    d.grant = q.cmd[key_limit_pkg::CMD_MATCH_BIT];
                    err = !q.cmd[key_limit_pkg::CMD_MATCH_BIT];
                    if (copy_ok && q.cmd[key_limit_pkg::CMD_MATCH_BIT]) begin
                        d.copy = 1'b1;
                        d.copy_slot = tgt;
                        d.scratch = 4'h9;
                    end
                end
            endcase
            d.status = {sel[3:0], d.copy, d.grant, err, 1'b1};
        end
        // data phase of a write: bitmaps can only lose bits
        if (q.active && q.wr) begin
            unique case (q.addr)
                key_limit_pkg::OFS_CMD: begin
                    d.cmd = hwdata;
                    d.fsm = ST_EXEC;
                    d.status[key_limit_pkg::STS_DONE] = 1'b0;
                end
                key_limit_pkg::OFS_ONE_SHOT: d.one_shot = hwdata[15:0];
                key_limit_pkg::OFS_REFRESH_OK: d.refresh_ok = hwdata[15:0];
                key_limit_pkg::OFS_RKEY_ZERO: d.rkey_zero = hwdata[15:0];
                key_limit_pkg::OFS_REMAIN_LO: d.remain[31:0] = d.remain[31:0] & hwdata;
                key_limit_pkg::OFS_REMAIN_HI: d.remain[63:32] = d.remain[63:32] & hwdata;
                key_limit_pkg::OFS_SCRATCH: d.scratch = hwdata[3:0];
                default: begin
                    if (q.addr >= key_limit_pkg::OFS_FINAL0 && q.addr <= key_limit_pkg::OFS_FINAL3) begin
                        d.final_map = final_and(d.final_map, 2'(q.addr[7:2] - 6'h11), hwdata);
                    end
                end
            endcase
        end
        // address phase capture and read data
        d.active = hready && hsel && htrans[1];
        d.wr = hwrite;
        d.addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFC;
        d.rdata = 32'h0;
        if (d.active && !hwrite) begin
            unique case (d.addr)
                key_limit_pkg::OFS_CMD: d.rdata = d.cmd;
                key_limit_pkg::OFS_STATUS: d.rdata = {24'h0, d.status};
                key_limit_pkg::OFS_ONE_SHOT: d.rdata = {16'h0, d.one_shot};
                key_limit_pkg::OFS_REFRESH_OK: d.rdata = {16'h0, d.refresh_ok};
                key_limit_pkg::OFS_RKEY_ZERO: d.rdata = {16'h0, d.rkey_zero};
                key_limit_pkg::OFS_REMAIN_LO: d.rdata = d.remain[31:0];
                key_limit_pkg::OFS_REMAIN_HI: d.rdata = d.remain[63:32];
                key_limit_pkg::OFS_SCRATCH: d.rdata = {28'h0, d.scratch};
                default: begin
                    if (d.addr >= key_limit_pkg::OFS_FINAL0 && d.addr <= key_limit_pkg::OFS_FINAL3) begin
                        d.rdata = final_word(d.final_map, 2'(d.addr[7:2] - 6'h11));
                    end
                end
            endcase
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ready <= 1'b1;
            q.remain <= {8{key_limit_pkg::BITMAP_FULL}};
            q.final_map <= key_limit_pkg::FINAL_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register, except hresp which is tied low
    assign hreadyout = q.ready;
    assign hrdata = q.rdata;
    assign hresp = 1'b0;
    assign key_use_grant = q.grant;
    assign key_slot = q.slot;
    assign hash_selector = q.selector;
    assign copy_strobe = q.copy;
    assign copy_slot = q.copy_slot;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic quiet;
    assign quiet = !(q.active && q.wr);

    high_slots_free_a: assert property (
        exec && quiet && op == OP_CRYPTO_USE && sel[3:0] > 4'h7 && sel[3:0] < 4'hF
        |=> key_use_grant && $stable(q.remain) && $stable(q.final_map))
        else $error("slot 8..14 was limited");
    empty_slot_err_a: assert property (
        exec && op == OP_CRYPTO_USE && sel[3:0] <= 4'h7 && q.one_shot[sel[3:0]] &&
        q.remain[sel[2:0]*8 +: 8] == 8'h00 |=> !key_use_grant && q.status[1])
        else $error("empty slot bitmap was granted");
    one_bit_clear_a: assert property (
        exec && quiet && op == OP_CRYPTO_USE && sel[3:0] <= 4'h7 && q.one_shot[sel[3:0]] &&
        q.remain[sel[2:0]*8 +: 8] != 8'h00
        |=> $countones(q.remain) == $countones($past(q.remain)) - 1)
        else $error("use did not clear exactly one bit");
    access_keeps_a: assert property (
        exec && quiet && op == OP_ACCESS |=> $stable(q.remain) && $stable(q.final_map))
        else $error("access changed a bitmap");
    parent_empty_a: assert property (
        exec && op == OP_REFRESH && q.refresh_ok[sel[3:0]] && is_limited(use_slot, q.one_shot)
        && ub.empty |=> !key_use_grant)
        else $error("refresh with empty parent granted");
    refresh_fill_a: assert property (
        exec && op == OP_REFRESH && sel[3:0] <= 4'h7 ##1 key_use_grant && quiet
        |-> q.remain[$past(sel[2:0])*8 +: 8] == 8'hFF)
        else $error("refresh did not fill target");
    refresh_policy_a: assert property (
        exec && op == OP_REFRESH && !q.refresh_ok[sel[3:0]] |=> !key_use_grant)
        else $error("refresh without policy bit");
    final_empty_a: assert property (
        exec && op == OP_CRYPTO_USE && sel[3:0] == 4'hF && q.one_shot[15] &&
        q.final_map == 128'h0 |=> !key_use_grant)
        else $error("empty final bitmap granted");
    final_order_a: assert property (
        exec && quiet && op == OP_CRYPTO_USE && sel[3:0] == 4'hF && q.one_shot[15] &&
        q.final_map[127] |=> !q.final_map[127] && q.final_map[126:0] == $past(q.final_map[126:0]))
        else $error("byte 68 bit 7 not cleared first");
    final_no_set_a: assert property (
        1'b1 |=> (q.final_map & ~$past(q.final_map)) == 128'h0)
        else $error("final bitmap bit came back");
    copy_gate_a: assert property (
        copy_strobe |-> $past(copy_ok) && $past(exec) && $past(op == OP_COMPARE))
        else $error("copy without its conditions");
    copy_flags_a: assert property (
        exec && op == OP_COMPARE && copy_ok && q.cmd[2] && quiet
        |=> copy_strobe && q.scratch == 4'h9 && copy_slot == $past(tgt) ##1 !copy_strobe)
        else $error("copy flags wrong");
    selector_out_a: assert property (
        exec |=> hash_selector == $past(sel) && key_slot == $past(sel[3:0]))
        else $error("selector not presented");
endmodule

//--- testbench/ahb_host_model.sv
// host side of the key-use limiter: an AHB-Lite master doing single word transfers
// assumes its tasks are entered just after a rising edge of hclk
`timescale 1ns/1ns
module ahb_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic stuck
);
    // ************************************************
    // bus idle at time zero
    // ************************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stuck = 1'b0;
    end

    // waits for hready sampled high at a rising edge, never forever
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 32);
        if (hready !== 1'b1) begin
            stuck = 1'b1;
        end
    endtask

    // one transfer: address phase held until ready, then data phase until ready
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata; // read data taken at the closing edge
    endtask
endmodule

//--- testbench/key_use_limiter_tb_top.sv
// self-checking bench for the key-use limiter and its password copy gate
// assumes the limiter answers every transfer with zero wait states
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module key_use_limiter_tb_top;
    // ************************************************
    // signals, instances, monitors
    // ************************************************
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, stuck;
    logic key_use_grant, copy_strobe;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] key_slot, copy_slot;
    logic [15:0] hash_selector;
    int err_total = 0;
    int check_count = 0;
    int grants = 0;
    int copies = 0;
    assign hready = hreadyout;

    key_use_limiter i_key_use_limiter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .key_use_grant(key_use_grant), .key_slot(key_slot), .hash_selector(hash_selector),
        .copy_strobe(copy_strobe), .copy_slot(copy_slot));
    ahb_host_model i_ahb_host_model (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .stuck(stuck));

    // clock at 125 MHz
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // counts one-cycle pulses of grant and copy
    always @(posedge hclk) begin
        grants <= grants + int'(key_use_grant === 1'b1);
        copies <= copies + int'(copy_strobe === 1'b1);
    end

    // ************************************************
    // helpers
    // ************************************************
    task automatic results();
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        i_ahb_host_model.xfer(w, {24'h0, a}, d, r);
        if (stuck) begin
            err_total++;
            results();
        end
    endtask

    // command write, one idle cycle for execution, then status read
    task automatic run(input logic [31:0] c, output logic [7:0] s);
        logic [31:0] r;
        acc(1'b1, key_limit_pkg::OFS_CMD, c, r);
        @(posedge hclk);
        acc(1'b0, key_limit_pkg::OFS_STATUS, 32'h0, r);
        s = r[7:0];
    endtask

    function automatic logic [31:0] cw(input logic [1:0] op, input logic [15:0] sel,
        input logic [7:0] mode, input logic [3:0] par, input logic sec, input logic m);
        return {sel, mode, par, sec, m, op};
    endfunction

    // expected low status nibble: copy, grant, error, done
    function automatic logic [3:0] st(input logic cp, input logic e);
        return {cp, ~e, e, 1'b1};
    endfunction

    // clears the first set bit, byte 0 first, bit 7 first within a byte
    function automatic logic [127:0] drop_first(input logic [127:0] v);
        for (int j = 0; j < 16; j++) begin
            for (int b = 7; b >= 0; b--) begin
                if (v[8 * j + b]) begin
                    v[8 * j + b] = 1'b0;
                    return v;
                end
            end
        end
        return v;
    endfunction

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        logic [7:0] s, bm;
        logic [31:0] w;
        logic [127:0] fin, t;
        logic [15:0] cases [7];
        int n;
        cases = '{16'h0107, 16'h051F, 16'h050E, 16'h0306, 16'h0102, 16'h0104, 16'h0116};
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        acc(1'b0, key_limit_pkg::OFS_FINAL0, 32'h0, w);
        `CHK(w, 32'hFFFF_FFFF)
        acc(1'b1, 8'h80, 32'h1234_5678, w);
        acc(1'b0, 8'h80, 32'h0, w);
        `CHK(w, 32'h0)
        // slot 3 limited with three uses left; slots 5 and 15 limited too, slot 9 enabled but unlimited
        acc(1'b1, key_limit_pkg::OFS_ONE_SHOT, 32'h0000_8228, w);
        acc(1'b1, key_limit_pkg::OFS_REMAIN_LO, 32'h07FF_FFFF, w);
        bm = 8'h07;
        for (int i = 0; i < 4; i++) begin
            run(cw(2'h0, 16'h0003, 8'h00, 4'h0, 1'b0, 1'b0), s);
            `CHK(s[3:0], st(1'b0, bm == 8'h00))
            t = drop_first({120'h0, bm});
            bm = t[7:0];
            acc(1'b0, key_limit_pkg::OFS_REMAIN_LO, 32'h0, w);
            `CHK(w[31:24], bm)
        end
        `CHK(grants, 3)
        repeat (9) begin
            run(cw(2'h0, 16'h0009, 8'h00, 4'h0, 1'b0, 1'b0), s);
            `CHK(s[1], 1'b0)
        end
        run(cw(2'h1, 16'h0003, 8'h00, 4'h0, 1'b0, 1'b0), s);
        `CHK(s[1], 1'b0)
        run(cw(2'h0, 16'h0002, 8'h00, 4'h0, 1'b0, 1'b0), s);
        acc(1'b0, key_limit_pkg::OFS_REMAIN_LO, 32'h0, w);
        `CHK(w, 32'h00FF_FFFF)
        // key refresh: policy gate, target restore, exhausted parent
        run(cw(2'h2, 16'h0003, 8'h00, 4'h4, 1'b0, 1'b0), s);
        `CHK(s[1], 1'b1)
        acc(1'b1, key_limit_pkg::OFS_REFRESH_OK, 32'h0000_8008, w);
        run(cw(2'h2, 16'h0003, 8'h00, 4'h4, 1'b0, 1'b0), s);
        `CHK(s[3:0], st(1'b0, 1'b0))
        run(cw(2'h0, 16'h0003, 8'h00, 4'h0, 1'b0, 1'b0), s);
        acc(1'b1, key_limit_pkg::OFS_REMAIN_HI, 32'hFFFF_00FF, w);
        run(cw(2'h2, 16'h0003, 8'h00, 4'h5, 1'b0, 1'b0), s);
        `CHK(s[1], 1'b1)
        acc(1'b0, key_limit_pkg::OFS_REMAIN_LO, 32'h0, w);
        `CHK(w[31:24], 8'h7F)
        // key 15 with three uses spread over the first and last bytes
        acc(1'b1, key_limit_pkg::OFS_FINAL0, 32'h0000_0003, w);
        acc(1'b1, 8'h48, 32'h0, w);
        acc(1'b1, 8'h4C, 32'h0, w);
        acc(1'b1, key_limit_pkg::OFS_FINAL3, 32'h0100_0000, w);
        fin = {32'h0100_0000, 64'h0, 32'h0000_0003};
        run(cw(2'h1, 16'h000F, 8'h00, 4'h0, 1'b0, 1'b0), s);
        acc(1'b0, key_limit_pkg::OFS_FINAL3, 32'h0, w);
        `CHK(w, 32'h0100_0000)
        for (int i = 0; i < 4; i++) begin
            run(cw(2'h0, 16'h123F, 8'h00, 4'h0, 1'b0, 1'b0), s);
            `CHK(s[3:0], st(1'b0, fin == 128'h0))
            `CHK({key_slot, hash_selector}, 20'hF123F)
            fin = drop_first(fin);
            acc(1'b0, key_limit_pkg::OFS_FINAL0, 32'h0, w);
            `CHK(w, fin[31:0])
            acc(1'b0, key_limit_pkg::OFS_FINAL3, 32'h0, w);
            `CHK(w, fin[127:96])
        end
        acc(1'b1, key_limit_pkg::OFS_FINAL0, 32'hFFFF_FFFF, w);
        run(cw(2'h2, 16'h000F, 8'h00, 4'h4, 1'b0, 1'b0), s);
        acc(1'b0, key_limit_pkg::OFS_FINAL0, 32'h0, w);
        `CHK(w, 32'h0)
        // compare: mode, origin, read-key gate, secondary target, match
        foreach (cases[i]) begin
            acc(1'b1, key_limit_pkg::OFS_RKEY_ZERO, {32{cases[i][2]}}, w);
            acc(1'b1, key_limit_pkg::OFS_SCRATCH, {28'h0, cases[i][7:4]}, w);
            n = copies;
            run(cw(2'h3, cases[i][3] ? 16'h000E : 16'h0004, cases[i][15:8], 4'h0,
                cases[i][3], cases[i][1]), s);
            `CHK(s[3:0], st(cases[i][0], ~cases[i][1]))
            `CHK(copies, n + int'(cases[i][0]))
            if (cases[i][0]) `CHK(copy_slot, cases[i][3] ? 4'hF : 4'h4)
            acc(1'b0, key_limit_pkg::OFS_SCRATCH, 32'h0, w);
            `CHK(w[3:0], cases[i][0] ? 4'h9 : cases[i][7:4])
        end
        acc(1'b0, key_limit_pkg::OFS_FINAL3, 32'h0, w);
        `CHK(w, 32'h0)
        results();
    end
endmodule
